// file: rtl/tseq_edge.sv
`include "tseq_regs.svh"

module tseq_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`TSEQ_CHANS-1:0] cur,
  input wire logic [`TSEQ_CHANS-1:0] chan_mask,
  input wire tseq_pkg::tseq_kind_t kind,
  output logic hit
);
  import tseq_pkg::*;

  tseq_edge_st_t q, d;
  logic [`TSEQ_CHANS-1:0] ev;

  always_comb begin
    d.prev = cur;
    d.prev2 = q.prev;
    // One-sample pulse is the closest a sampled stream gets to a glitch
    case (kind)
      TSEQ_GLITCH: ev = (q.prev ^ q.prev2) & (q.prev ^ cur);
      TSEQ_RISE: ev = ~q.prev & cur;
      TSEQ_FALL: ev = q.prev & ~cur;
      default: ev = q.prev ^ cur;
    endcase
    if (kind == TSEQ_NONE) begin
      hit = ~|(ev & chan_mask);
    end else begin
      hit = |(ev & chan_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= `TSEQ_EDGE_RST;
    end else begin
      q <= d;
    end
  end

  a_edge_rise_hit: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == TSEQ_RISE && chan_mask[1] && $rose(cur[1])) |-> hit)
    else $error("rising edge on selected channel missed");
  a_edge_none_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (kind == TSEQ_NONE && chan_mask[1] && $changed(cur[1])) |-> !hit)
    else $error("no-edge term satisfied despite a transition");
endmodule

// file: rtl/tseq_pkg.sv
`include "tseq_regs.svh"

package tseq_pkg;
  typedef enum logic {TSEQ_TIMING = 1'b0, TSEQ_STATE = 1'b1} tseq_mode_t;
  typedef enum logic [2:0] {
    TSEQ_GLITCH = 3'b000, TSEQ_RISE = 3'b001, TSEQ_FALL = 3'b010, TSEQ_ANY = 3'b011, TSEQ_NONE = 3'b100
  } tseq_kind_t;
  typedef enum logic [2:0] {
    TSEQ_AND = 3'b000, TSEQ_NAND = 3'b001, TSEQ_OR = 3'b010, TSEQ_NOR = 3'b011, TSEQ_XOR = 3'b100,
    TSEQ_XNOR = 3'b101
  } tseq_op_t;
  // On doubles as in-range and less-than, negate as out-of-range and greater-than
  typedef enum logic [1:0] {TSEQ_OFF = 2'b00, TSEQ_ON = 2'b01, TSEQ_NEG = 2'b10} tseq_res_t;
  typedef enum logic {TSEQ_IDLE = 1'b0, TSEQ_RUN = 1'b1} tseq_fsm_t;

  typedef struct packed {
    logic [`TSEQ_CHANS-1:0] prev;
    logic [`TSEQ_CHANS-1:0] prev2;
  } tseq_edge_st_t;

  typedef struct packed {
    logic [`TSEQ_CHANS-1:0] sync1;
    logic [`TSEQ_CHANS-1:0] sync2;
    tseq_mode_t mode;
    logic [3:0] last_cfg;
    logic [3:0] trig_cfg;
    tseq_fsm_t fsm;
    logic [3:0] level;
    logic trig_seen;
    logic trig;
    logic [2:0] istat;
    logic [2:0] imask;
    logic irq;
    logic [1:0][31:0] tpre;
    logic [1:0][31:0] tcnt;
    logic [1:0][31:0] rlo;
    logic [1:0][31:0] rhi;
    logic [1:0] rsel;
    logic [1:0][`TSEQ_CHANS-1:0] emask;
    logic [1:0][2:0] ekind;
    logic [`TSEQ_PATTERNS-1:0][`TSEQ_CHANS-1:0] pval;
    logic [`TSEQ_PATTERNS-1:0][`TSEQ_CHANS-1:0] pcare;
    logic [`TSEQ_LEVELS-1:0][31:0] lops;
    logic [`TSEQ_LEVELS-1:0][26:0] llink;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tseq_state_t;
endpackage

// file: rtl/tseq_range.sv
`include "tseq_regs.svh"

module tseq_range (
  input wire logic [`TSEQ_CHANS-1:0] samp,
  input wire logic pair_sel,
  input wire logic [31:0] lo,
  input wire logic [31:0] hi,
  output logic in_rng
);
  logic [31:0] word;

  // Only pods 1/2 or 3/4 can form a 32-bit word; no even/odd straddle exists
  always_comb begin
    word = pair_sel ? samp[4*`TSEQ_POD_W-1:2*`TSEQ_POD_W] : samp[2*`TSEQ_POD_W-1:0];
    in_rng = (word >= lo) && (word <= hi);
  end
endmodule

// file: rtl/tseq_regs.svh
`ifndef TSEQ_REGS_SVH
`define TSEQ_REGS_SVH

// Probe width, pod width and resource counts
`define TSEQ_CHANS 64
`define TSEQ_POD_W 16
`define TSEQ_PATTERNS 10
`define TSEQ_LEVELS 12
`define TSEQ_LAST_TIMING 4'h9
`define TSEQ_LAST_STATE 4'hB

// Register byte offsets
`define TSEQ_CTRL_OFS 12'h000
`define TSEQ_STATUS_OFS 12'h004
`define TSEQ_ISTAT_OFS 12'h008
`define TSEQ_IMASK_OFS 12'h00C
`define TSEQ_TPRE0_OFS 12'h010
`define TSEQ_TPRE1_OFS 12'h014
`define TSEQ_RLO0_OFS 12'h020
`define TSEQ_RHI0_OFS 12'h024
`define TSEQ_RSEL0_OFS 12'h028
`define TSEQ_RLO1_OFS 12'h030
`define TSEQ_RHI1_OFS 12'h034
`define TSEQ_RSEL1_OFS 12'h038
`define TSEQ_EMLO0_OFS 12'h040
`define TSEQ_EMHI0_OFS 12'h044
`define TSEQ_EKIND0_OFS 12'h048
`define TSEQ_EMLO1_OFS 12'h050
`define TSEQ_EMHI1_OFS 12'h054
`define TSEQ_EKIND1_OFS 12'h058
`define TSEQ_PAT_PAGE 4'h1
`define TSEQ_LVL_PAGE 4'h2

// Field positions
`define TSEQ_CTRL_MODE 0
`define TSEQ_CTRL_RUN 1
`define TSEQ_CTRL_LAST 4
`define TSEQ_CTRL_TRIG 8
`define TSEQ_EV_TRIG 0
`define TSEQ_EV_DONE 1
`define TSEQ_EV_STEP 2
`define TSEQ_LINK_GRP 24
`define TSEQ_LINK_TOP 26

// Reset values
`define TSEQ_STATE_RST '0
`define TSEQ_EDGE_RST '0

`endif

// file: rtl/tseq_top.sv
// Contract
// - Timing mode offers ten sequence levels.
// - Timing mode fires the trigger at the final used level.
// - Timing mode ignores pattern terms eight and ten.
// - Timing mode adds two edge terms to pattern, range and timer terms.
// - Edge term detects glitch, rise, fall, any edge or no edge.
// - State mode offers twelve sequence levels.
// - State mode never fires the trigger at the final used level.
// - State mode excludes both edge terms from every expression.
// - State mode may use all ten pattern terms.
// - Multi-pod range uses pods 1/2 or 3/4 only, never even/odd.
// - Multi-channel edge term hits when any selected channel qualifies; no-edge hits only when every selected channel is quiet.
// - Range term matches inside bounds, or outside when set out-of-range.
// - Timer terms are excluded in the first sequence level.
// - Terms on/off/negated, pairs by six ops, pairs and groups by AND/OR.
`include "tseq_regs.svh"

module tseq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`TSEQ_CHANS-1:0] probe,
  output logic irq,
  output logic trig,
  output logic [3:0] level,
  output logic running
);
  import tseq_pkg::*;

  function automatic logic [1:0] tseq_join(input logic ia, input logic va, input logic ib, input logic vb,
                                           input tseq_op_t op);
    logic r;
    r = 1'b0;
    if (ia && ib) begin
      case (op)
        TSEQ_AND: r = va & vb;
        TSEQ_NAND: r = ~(va & vb);
        TSEQ_OR: r = va | vb;
        TSEQ_NOR: r = ~(va | vb);
        TSEQ_XOR: r = va ^ vb;
        TSEQ_XNOR: r = ~(va ^ vb);
        default: r = 1'b0;
      endcase
      return {1'b1, r};
    end else if (ia) begin
      return {1'b1, va};
    end else if (ib) begin
      return {1'b1, vb};
    end
    return 2'b00;
  endfunction

  function automatic tseq_op_t tseq_andor(input logic use_or);
    return use_or ? TSEQ_OR : TSEQ_AND;
  endfunction

  tseq_state_t q, d;
  logic [`TSEQ_PATTERNS-1:0] pat_hit;
  logic [1:0] rng_hit;
  logic [1:0] edge_hit;
  logic [15:0] res_inc;
  logic [15:0] res_val;
  logic [7:0][1:0] pair_r;
  logic [1:0][1:0] grp_r;
  logic [1:0] top_r;
  logic sat;
  logic [31:0] ops;
  logic [26:0] links;
  logic [1:0] op;
  logic sig;
  int pidx;
  logic [31:0] rd;
  logic ok;
  logic wr;
  logic run_go;
  logic [2:0] clr;
  logic [2:0] ev;
  logic [3:0] cap;
  logic [3:0] last;
  logic [3:0] trg;

  ////////////////////////////////////////////////////////////////////////////
  // Term resources

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_res
      tseq_range u_range (
        .samp(q.sync2),
        .pair_sel(q.rsel[gi]),
        .lo(q.rlo[gi]),
        .hi(q.rhi[gi]),
        .in_rng(rng_hit[gi])
      );
      tseq_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .cur(q.sync2),
        .chan_mask(q.emask[gi]),
        .kind(tseq_kind_t'(q.ekind[gi])),
        .hit(edge_hit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Expression of the current level

  always_comb begin
    ops = q.lops[q.level];
    links = q.llink[q.level];
    op = 2'b00;
    sig = 1'b0;
    pidx = 0;
    res_inc = '0;
    res_val = '0;
    for (int i = 0; i < `TSEQ_PATTERNS; i++) begin
      pat_hit[i] = ~|((q.sync2 ^ q.pval[i]) & q.pcare[i]);
    end
    // Slot order per group: pat, pat, pat, range, pat, edge, pat, timer
    for (int g = 0; g < 2; g++) begin
      for (int s = 0; s < 8; s++) begin
        op = ops[2*(8*g+s) +: 2];
        pidx = 5 * g + ((s < 3) ? s : s / 2 + 1);
        case (s)
          3: sig = rng_hit[g];
          5: sig = edge_hit[g];
          7: sig = q.tcnt[g] < q.tpre[g];
          default: sig = pat_hit[pidx];
        endcase
        if (s == 7 && op == TSEQ_NEG) begin
          res_val[8*g+s] = q.tcnt[g] > q.tpre[g];
        end else begin
          res_val[8*g+s] = sig ^ (op == TSEQ_NEG);
        end
        res_inc[8*g+s] = (op == TSEQ_ON) || (op == TSEQ_NEG);
        if (q.mode == TSEQ_TIMING && g == 1 && (s == 2 || s == 6)) begin
          res_inc[8*g+s] = 1'b0;
        end
        if (q.mode == TSEQ_STATE && s == 5) begin
          res_inc[8*g+s] = 1'b0;
        end
        if (q.level == 4'h0 && s == 7) begin
          res_inc[8*g+s] = 1'b0;
        end
      end
    end
    for (int p = 0; p < 8; p++) begin
      pair_r[p] = tseq_join(res_inc[2*p], res_val[2*p], res_inc[2*p+1], res_val[2*p+1],
                            tseq_op_t'(links[3*p +: 3]));
    end
    for (int g = 0; g < 2; g++) begin
      grp_r[g] = pair_r[4*g];
      for (int p = 1; p < 4; p++) begin
        grp_r[g] = tseq_join(grp_r[g][1], grp_r[g][0], pair_r[4*g+p][1], pair_r[4*g+p][0],
                             tseq_andor(links[`TSEQ_LINK_GRP+g]));
      end
    end
    top_r = tseq_join(grp_r[0][1], grp_r[0][0], grp_r[1][1], grp_r[1][0],
                      tseq_andor(links[`TSEQ_LINK_TOP]));
    // An expression with every term off never matches
    sat = top_r[1] & top_r[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, sequencer, interrupt

  always_comb begin
    d = q;
    d.sync1 = probe;
    d.sync2 = q.sync1;
    rd = '0;
    ok = 1'b1;
    clr = '0;
    run_go = 1'b0;
    // Write lands on the edge where the master sees pready
    wr = psel & penable & q.pready & pwrite;
    case (paddr[11:8])
      `TSEQ_PAT_PAGE: begin
        if (paddr[7:4] < 4'hA) begin
          case (paddr[3:2])
            2'h0: rd = q.pval[paddr[7:4]][31:0];
            2'h1: rd = q.pval[paddr[7:4]][63:32];
            2'h2: rd = q.pcare[paddr[7:4]][31:0];
            default: rd = q.pcare[paddr[7:4]][63:32];
          endcase
          if (wr) begin
            case (paddr[3:2])
              2'h0: d.pval[paddr[7:4]][31:0] = pwdata;
              2'h1: d.pval[paddr[7:4]][63:32] = pwdata;
              2'h2: d.pcare[paddr[7:4]][31:0] = pwdata;
              default: d.pcare[paddr[7:4]][63:32] = pwdata;
            endcase
          end
        end else begin
          ok = 1'b0;
        end
      end
      `TSEQ_LVL_PAGE: begin
        if (paddr[7:3] < 5'h0C) begin
          rd = paddr[2] ? {5'h00, q.llink[paddr[6:3]]} : q.lops[paddr[6:3]];
          if (wr && paddr[2]) begin
            d.llink[paddr[6:3]] = pwdata[26:0];
          end else if (wr) begin
            d.lops[paddr[6:3]] = pwdata;
          end
        end else begin
          ok = 1'b0;
        end
      end
      4'h0: begin
        case (paddr)
          `TSEQ_CTRL_OFS: begin
            rd = {20'h00000, q.trig_cfg, q.last_cfg, 3'h0, q.mode};
            if (wr) begin
              d.mode = tseq_mode_t'(pwdata[`TSEQ_CTRL_MODE]);
              d.last_cfg = pwdata[`TSEQ_CTRL_LAST +: 4];
              d.trig_cfg = pwdata[`TSEQ_CTRL_TRIG +: 4];
              run_go = pwdata[`TSEQ_CTRL_RUN];
            end
          end
          `TSEQ_STATUS_OFS: rd = {24'h000000, q.level, 2'h0, q.trig_seen, q.fsm == TSEQ_RUN};
          `TSEQ_ISTAT_OFS: begin
            rd = {29'h00000000, q.istat};
            clr = wr ? pwdata[2:0] : 3'h0;
          end
          `TSEQ_IMASK_OFS: begin
            rd = {29'h00000000, q.imask};
            if (wr) d.imask = pwdata[2:0];
          end
          `TSEQ_TPRE0_OFS, `TSEQ_TPRE1_OFS: begin
            rd = q.tpre[paddr[2]];
            if (wr) d.tpre[paddr[2]] = pwdata;
          end
          `TSEQ_RLO0_OFS, `TSEQ_RLO1_OFS: begin
            rd = q.rlo[paddr[4]];
            if (wr) d.rlo[paddr[4]] = pwdata;
          end
          `TSEQ_RHI0_OFS, `TSEQ_RHI1_OFS: begin
            rd = q.rhi[paddr[4]];
            if (wr) d.rhi[paddr[4]] = pwdata;
          end
          `TSEQ_RSEL0_OFS, `TSEQ_RSEL1_OFS: begin
            rd = {31'h00000000, q.rsel[paddr[4]]};
            if (wr) d.rsel[paddr[4]] = pwdata[0];
          end
          `TSEQ_EMLO0_OFS, `TSEQ_EMLO1_OFS: begin
            rd = q.emask[paddr[4]][31:0];
            if (wr) d.emask[paddr[4]][31:0] = pwdata;
          end
          `TSEQ_EMHI0_OFS, `TSEQ_EMHI1_OFS: begin
            rd = q.emask[paddr[4]][63:32];
            if (wr) d.emask[paddr[4]][63:32] = pwdata;
          end
          `TSEQ_EKIND0_OFS, `TSEQ_EKIND1_OFS: begin
            rd = {29'h00000000, q.ekind[paddr[4]]};
            if (wr) d.ekind[paddr[4]] = pwdata[2:0];
          end
          default: ok = 1'b0;
        endcase
      end
      default: ok = 1'b0;
    endcase
    d.pready = psel & penable & ~q.pready;
    d.pslverr = d.pready & ~ok;
    d.prdata = (d.pready && ok) ? rd : 32'h00000000;
    if (!ok) begin
      d = q;
      d.sync1 = probe;
      d.sync2 = q.sync1;
      d.pready = psel & penable & ~q.pready;
      d.pslverr = d.pready;
      d.prdata = 32'h00000000;
      run_go = 1'b0;
    end

    // Level ceiling and trigger placement follow the mode
    cap = (q.mode == TSEQ_STATE) ? `TSEQ_LAST_STATE : `TSEQ_LAST_TIMING;
    last = (q.last_cfg > cap) ? cap : q.last_cfg;
    if (q.mode == TSEQ_STATE && last == 4'h0) begin
      last = 4'h1;
    end
    if (q.mode == TSEQ_TIMING) begin
      trg = last;
    end else begin
      trg = (q.trig_cfg >= last) ? last - 4'h1 : q.trig_cfg;
    end
    ev = '0;
    d.trig = 1'b0;
    if (q.fsm == TSEQ_RUN) begin
      d.tcnt[0] = (q.tcnt[0] == 32'hFFFFFFFF) ? q.tcnt[0] : q.tcnt[0] + 32'h00000001;
      d.tcnt[1] = (q.tcnt[1] == 32'hFFFFFFFF) ? q.tcnt[1] : q.tcnt[1] + 32'h00000001;
      if (sat) begin
        if (q.level == trg) begin
          d.trig = 1'b1;
          d.trig_seen = 1'b1;
          ev[`TSEQ_EV_TRIG] = 1'b1;
        end
        if (q.level >= last) begin
          d.fsm = TSEQ_IDLE;
          ev[`TSEQ_EV_DONE] = 1'b1;
        end else begin
          d.level = q.level + 4'h1;
          d.tcnt = '0;
          ev[`TSEQ_EV_STEP] = 1'b1;
        end
      end
    end
    if (run_go) begin
      d.fsm = TSEQ_RUN;
      d.level = 4'h0;
      d.trig_seen = 1'b0;
      d.tcnt = '0;
    end
    // A new event beats a clear in the same cycle
    d.istat = (q.istat & ~clr) | ev;
    d.irq = |(d.istat & d.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= `TSEQ_STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign trig = q.trig;
  assign level = q.level;
  assign running = q.fsm == TSEQ_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_timing_level_cap: assert property (q.mode == TSEQ_TIMING && q.fsm == TSEQ_RUN |-> q.level <= 4'h9)
    else $error("timing level beyond ten");
  a_state_level_cap: assert property (q.fsm == TSEQ_RUN |-> q.level <= 4'hB)
    else $error("state level beyond twelve");
  a_timing_trig_last: assert property ((q.fsm == TSEQ_RUN && sat && q.mode == TSEQ_TIMING && !run_go)
    |=> q.trig == (q.fsm == TSEQ_IDLE))
    else $error("timing trigger not at final level");
  a_state_trig_room: assert property ((q.mode == TSEQ_STATE && !run_go && q.fsm == TSEQ_RUN && sat
    && q.level == trg) |=> q.trig && q.fsm == TSEQ_RUN)
    else $error("state trigger left no following level");
  a_hj_unused: assert property (q.mode == TSEQ_TIMING |-> !res_inc[10] && !res_inc[14])
    else $error("pattern h or j used in timing mode");
  a_edge_unused: assert property (q.mode == TSEQ_STATE |-> !res_inc[5] && !res_inc[13])
    else $error("edge term used in state mode");
  a_timer_first_lvl: assert property (q.level == 4'h0 |-> !res_inc[7] && !res_inc[15])
    else $error("timer used in first level");
  a_empty_expr: assert property (res_inc == 16'h0000 |-> !sat)
    else $error("empty expression matched");
  a_run_restart: assert property (run_go |=> q.level == 4'h0 && q.fsm == TSEQ_RUN ##1 q.level <= 4'h1)
    else $error("run did not restart at first level");
  a_step_one: assert property ((q.fsm == TSEQ_RUN && sat && !run_go && q.level < last)
    |=> q.level == $past(q.level) + 4'h1)
    else $error("level did not advance by one");
endmodule

// file: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tseq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, trig, running, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] want, probe;
  logic [3:0] level;
  int fail_count, compares;
  logic [31:0] r_ops[6] = '{32'h40, 32'h40, 32'h80, 32'h80, 32'h40, 32'h40};
  logic r_sel[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [63:0] r_pv[6] = '{64'h20, 64'h21, 64'h21, 64'h10, 64'h20_0000_0000, 64'h20};
  logic r_exp[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [31:0] o_ops[10] = '{32'h5, 32'h5, 32'h5, 32'h5, 32'h5, 32'h5, 32'h9, 32'h14, 32'h14, 32'h10004};
  logic [31:0] o_link[10] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h0, 32'h0, 32'h0100_0000, 32'h0400_0000};
  logic o_exp[10] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [4:0] ek_exp = 5'b11010;

  tseq_top tseq_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .probe(probe),
    .irq(irq), .trig(trig), .level(level), .running(running));
  tseq_sut tseq_sut_i (.pclk(pclk), .want(want), .probe(probe));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_w(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_b(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Request holds until pready is seen high at a rising edge; read data taken at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (ok !== 1'b1 && n < 20) begin
      @(posedge pclk);
      ok = pready;
      rd = prdata;
      err = pslverr;
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] pready expected 1 seen %b", ok);
      close_out();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk_w(nm, exp, rd);
    chk_b(nm, eerr, err);
  endtask

  task automatic lvl(input int l, input logic [31:0] ops, input logic [31:0] link);
    wr(12'h200 + 12'(8 * l), ops);
    wr(12'h204 + 12'(8 * l), link);
  endtask

  task automatic go(input logic md, input logic [3:0] last, input logic [3:0] tl);
    wr(12'h000, {20'h0, tl, last, 2'b00, 1'b1, md});
  endtask

  // Two-level run (last level 1): level ends at 1 only if level 0 matched
  task automatic try(input string nm, input logic md, input logic [31:0] ops, input logic [31:0] link,
                     input logic [63:0] p0, input logic [63:0] p1, input logic exp);
    lvl(0, ops, link);
    want <= p0;
    repeat (4) @(posedge pclk);
    go(md, 4'h1, 4'h0);
    want <= p1;
    repeat (12) @(posedge pclk);
    chk_w(nm, {31'h0, exp}, {28'h0, level});
  endtask

  // Level that fired is the one held just before the trigger pulse
  task automatic seq(input string nm, input logic md, input logic [3:0] xlast, input logic [3:0] xfire);
    int mx, fl, nt;
    logic [3:0] pv;
    mx = 0;
    fl = 0;
    nt = 0;
    pv = 4'h0;
    go(md, 4'hF, 4'hF);
    repeat (80) begin
      @(negedge pclk);
      if (trig === 1'b1) begin
        nt++;
        fl = pv;
      end
      if (level > mx) begin
        mx = level;
      end
      pv = level;
    end
    @(posedge pclk);
    chk_w({nm, "_last"}, {28'h0, xlast}, 32'(mx));
    chk_w({nm, "_fire"}, {28'h0, xfire}, 32'(fl));
    chk_w({nm, "_trigs"}, 32'h1, 32'(nt));
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 64'h0;
    presetn = 1'b0;
    fail_count = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("ctrl_rst", 12'h000, 32'h0, 1'b0);
    rdchk("status_rst", 12'h004, 32'h0, 1'b0);
    rdchk("istat_rst", 12'h008, 32'h0, 1'b0);
    rdchk("unmapped", 12'h0FC, 32'h0, 1'b1);
    for (int l = 0; l < 12; l++) begin
      lvl(l, 32'h1, 32'h0);
    end
    seq("timing", 1'b0, 4'h9, 4'h9);
    seq("state", 1'b1, 4'hB, 4'hA);
    // Interrupt path: sticky events, mask, write-one clear
    rdchk("istat_ev", 12'h008, 32'h7, 1'b0);
    chk_b("irq_masked", 1'b0, irq);
    wr(12'h00C, 32'h1);
    repeat (2) @(posedge pclk);
    chk_b("irq_on", 1'b1, irq);
    wr(12'h008, 32'h7);
    repeat (2) @(posedge pclk);
    chk_b("irq_off", 1'b0, irq);
    rdchk("istat_clr", 12'h008, 32'h0, 1'b0);
    try("pat_h_tim", 1'b0, 32'h0010_0000, 32'h0, 64'h0, 64'h0, 1'b0);
    try("pat_j_tim", 1'b0, 32'h1000_0000, 32'h0, 64'h0, 64'h0, 1'b0);
    try("pat_h_st", 1'b1, 32'h0010_0000, 32'h0, 64'h0, 64'h0, 1'b1);
    try("pat_j_st", 1'b1, 32'h1000_0000, 32'h0, 64'h0, 64'h0, 1'b1);
    // Step on bit 1 only, mask covers bits 0 and 1
    wr(12'h040, 32'h3);
    for (int k = 0; k < 5; k++) begin
      wr(12'h048, 32'(k));
      try("edge_kind", 1'b0, 32'h400, 32'h0, 64'h0, 64'h2, ek_exp[k]);
    end
    wr(12'h048, 32'h3);
    try("edge_state", 1'b1, 32'h400, 32'h0, 64'h0, 64'h2, 1'b0);
    wr(12'h020, 32'h10);
    wr(12'h024, 32'h20);
    for (int i = 0; i < 6; i++) begin
      wr(12'h028, {31'h0, r_sel[i]});
      try("range", 1'b0, r_ops[i], 32'h0, r_pv[i], r_pv[i], r_exp[i]);
    end
    // Term b never matches an all-zero probe
    wr(12'h110, 32'h1);
    wr(12'h118, 32'h1);
    for (int i = 0; i < 10; i++) begin
      try("combine", 1'b1, o_ops[i], o_link[i], 64'h0, 64'h0, o_exp[i]);
    end
    wr(12'h010, 32'h64);
    try("timer_first", 1'b0, 32'h4000, 32'h0, 64'h0, 64'h0, 1'b0);
    lvl(1, 32'h4000, 32'h0);
    lvl(0, 32'h1, 32'h0);
    go(1'b0, 4'h2, 4'h0);
    repeat (12) @(posedge pclk);
    chk_w("timer_later", 32'h2, {28'h0, level});
    lvl(0, 32'h0, 32'h0);
    go(1'b0, 4'h2, 4'h0);
    repeat (4) @(posedge pclk);
    chk_w("restart_lvl", 32'h0, {28'h0, level});
    chk_b("restart_run", 1'b1, running);
    close_out();
  end
endmodule

// file: sim/tseq_sut.sv
module tseq_sut (
  input wire logic pclk,
  input wire logic [63:0] want,
  output logic [63:0] probe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Target logic switches on the sample clock, so pods never change mid-cycle
  always_ff @(posedge pclk) begin
    probe <= want;
  end
endmodule
